// *** src/dsf_flag_cell.sv ***
// One sticky active-low fault flag with write-one restore
`default_nettype none
module dsf_flag_cell
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic event_i, // Fault event pulse
	input wire logic clear_i, // Write of one to this bit
	output logic flag_o // 0 once a fault has occurred
);
	// ==========================================================
	// Flag state
	logic flag_d;
	logic flag_q;

	// Next value: a fault beats a clearing write
	always_comb
	begin
		flag_d = flag_q;
		if (event_i)
		begin
			flag_d = 1'b0; // R17
		end
		else if (clear_i)
		begin
			flag_d = 1'b1;
		end
	end

	// Register; reset shows no fault
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			flag_q <= 1'b1;
		end
		else
		begin
			flag_q <= flag_d;
		end
	end

	assign flag_o = flag_q;

	// ==========================================================
	// Checks
	sequence s_quiet;
		!event_i && !clear_i;
	endsequence

	property p_fault_wins;
		@(posedge clk_i) disable iff (!rstn_i)
		event_i |=> !flag_o;
	endproperty
	a_fault_wins: assert property (p_fault_wins) // R17
		else $error("flag not low after fault");

	property p_restore;
		@(posedge clk_i) disable iff (!rstn_i)
		(clear_i && !event_i) ##1 s_quiet [*2] |-> flag_o;
	endproperty
	a_restore: assert property (p_restore) // R17
		else $error("flag not restored by write of one");

	property p_hold;
		@(posedge clk_i) disable iff (!rstn_i)
		s_quiet |=> $stable(flag_o);
	endproperty
	a_hold: assert property (p_hold) // R17
		else $error("flag changed without cause");
endmodule
`default_nettype wire

// *** src/dsf_params.svh ***
// Offsets, field positions, reset values and sizes of the status flag bank
//
// Behaviour
// [R1] Clock status at 04h, reset FC07h, fixed upper bits
// [R2] Bit 2 drops on main clock frequency fault
// [R3] Bit 1 drops on diagnostic oscillator watchdog fault
// [R4] Bit 0 drops on main clock watchdog fault
// [R5] Digital bit 15 drops on section one CRC
// [R6] Digital bit 14 drops on section two CRC
// [R7] Digital bit 13 drops on section three CRC
// [R8] Digital status at 05h, reset EC00h, reserved zero
// [R9] Digital bit 11 drops on memory CRC fault
// [R10] Host resets device if memory flag persists
// [R11] Bit 10 shows selected fuse bank, read-only
// [R12] Fuse bank bit excluded from summary fault
// [R13] Host resets device when backup bank used
// [R14] Overcurrent status at 06h, reset 000Fh
// [R15] Bits 3 and 1 drop on high limit
// [R16] Bits 2 and 0 drop on low limit
// [R17] Writing zero keeps flag; fault beats clear
`ifndef DSF_PARAMS_SVH
`define DSF_PARAMS_SVH

// ==========================================================
// Register offsets
`define DSF_ADDR_W 8
`define DSF_OFS_CLOCK 8'h04
`define DSF_OFS_DIGITAL 8'h05
`define DSF_OFS_OCC 8'h06

// ==========================================================
// Reset values and fixed fields
`define DSF_RST_CLOCK 16'hFC07
`define DSF_RST_DIGITAL 16'hEC00
`define DSF_RST_OCC 16'h000F
`define DSF_CLK_RSVD 13'h1F80
`define DSF_OCC_RSVD 12'h000
`define DSF_DIG_LOW_RSVD 10'h000

// ==========================================================
// Flag indices inside the flag vector
`define DSF_NUM_FLAGS 11
`define DSF_F_MCLK_WD 0
`define DSF_F_OSC_WD 1
`define DSF_F_MCLK_FREQ 2
`define DSF_F_SEC_ONE 3
`define DSF_F_SEC_TWO 4
`define DSF_F_SEC_THREE 5
`define DSF_F_MEM 6
`define DSF_F_B_LOW 7
`define DSF_F_B_HIGH 8
`define DSF_F_A_LOW 9
`define DSF_F_A_HIGH 10

// ==========================================================
// Bit positions inside the registers
`define DSF_B_SEC_ONE 15
`define DSF_B_SEC_TWO 14
`define DSF_B_SEC_THREE 13
`define DSF_B_MEM 11
`define DSF_B_BANK 10

`endif

// *** src/dsf_pkg.sv ***
// Types shared by the status flag bank
`default_nettype none
package dsf_pkg;
	// One status register word
	typedef logic [15:0] dsf_word_t;
	// Register selected by the decoded address
	typedef enum logic [1:0] {
		DSF_SEL_NONE,
		DSF_SEL_CLOCK,
		DSF_SEL_DIGITAL,
		DSF_SEL_OCC
	} dsf_sel_t;
endpackage
`default_nettype wire

// *** src/dsf_status_regs.sv ***
// Diagnostic status register bank: clock, digital and overcurrent flags
`include "dsf_params.svh"
`default_nettype none
module dsf_status_regs
(
	input wire logic clk_i,
	input wire logic rstn_i,
	// Register port, same clock domain
	input wire logic [`DSF_ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i, // Write strobe, one cycle
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_rd_i, // Read strobe, one cycle
	output logic [15:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Fault event pulses from the on-chip monitors
	input wire logic main_clk_freq_fault_i,
	input wire logic diag_osc_watchdog_i,
	input wire logic main_clk_watchdog_i,
	input wire logic regsec_one_crc_i,
	input wire logic regsec_two_crc_i,
	input wire logic regsec_three_crc_i,
	input wire logic internal_memory_crc_i,
	input wire logic chan_a_high_limit_i,
	input wire logic chan_a_low_limit_i,
	input wire logic chan_b_high_limit_i,
	input wire logic chan_b_low_limit_i,
	// Fuse loader: 1 when the primary bank was chosen
	input wire logic fuse_bank_primary_i,
	// Summary digital fault, low when any digital flag is low
	output logic summary_digital_fault_n_o
);
	// ==========================================================
	// Address decode
	dsf_pkg::dsf_sel_t sel; // Register addressed this cycle

	// Map the offset onto a register select
	always_comb
	begin
		case (reg_addr_i)
			`DSF_OFS_CLOCK: sel = dsf_pkg::DSF_SEL_CLOCK; // R1
			`DSF_OFS_DIGITAL: sel = dsf_pkg::DSF_SEL_DIGITAL; // R8
			`DSF_OFS_OCC: sel = dsf_pkg::DSF_SEL_OCC; // R14
			default: sel = dsf_pkg::DSF_SEL_NONE;
		endcase
	end

	// ==========================================================
	// Event and clear vectors
	logic [`DSF_NUM_FLAGS-1:0] events; // Fault pulses by flag index
	logic [`DSF_NUM_FLAGS-1:0] clears; // Write-one restores by index
	logic [`DSF_NUM_FLAGS-1:0] flags; // Current flag values

	// Gather the event pulses
	always_comb
	begin
		events = '0;
		events[`DSF_F_MCLK_WD] = main_clk_watchdog_i; // R4
		events[`DSF_F_OSC_WD] = diag_osc_watchdog_i; // R3
		events[`DSF_F_MCLK_FREQ] = main_clk_freq_fault_i; // R2
		events[`DSF_F_SEC_ONE] = regsec_one_crc_i; // R5
		events[`DSF_F_SEC_TWO] = regsec_two_crc_i; // R6
		events[`DSF_F_SEC_THREE] = regsec_three_crc_i; // R7
		events[`DSF_F_MEM] = internal_memory_crc_i; // R9
		events[`DSF_F_B_LOW] = chan_b_low_limit_i; // R16
		events[`DSF_F_B_HIGH] = chan_b_high_limit_i; // R15
		events[`DSF_F_A_LOW] = chan_a_low_limit_i; // R16
		events[`DSF_F_A_HIGH] = chan_a_high_limit_i; // R15
	end

	// Route written ones to flags; zeros and reserved bits do nothing
	always_comb
	begin
		clears = '0;
		if (reg_wr_i)
		begin
			case (sel)
				dsf_pkg::DSF_SEL_CLOCK:
				begin
					clears[`DSF_F_MCLK_WD] = reg_wdata_i[0]; // R4
					clears[`DSF_F_OSC_WD] = reg_wdata_i[1]; // R3
					clears[`DSF_F_MCLK_FREQ] = reg_wdata_i[2]; // R2
				end
				dsf_pkg::DSF_SEL_DIGITAL:
				begin
					clears[`DSF_F_SEC_ONE] =
						reg_wdata_i[`DSF_B_SEC_ONE]; // R5
					clears[`DSF_F_SEC_TWO] =
						reg_wdata_i[`DSF_B_SEC_TWO]; // R6
					clears[`DSF_F_SEC_THREE] =
						reg_wdata_i[`DSF_B_SEC_THREE]; // R7
					clears[`DSF_F_MEM] = reg_wdata_i[`DSF_B_MEM]; // R9
				end
				dsf_pkg::DSF_SEL_OCC:
				begin
					clears[`DSF_F_B_LOW] = reg_wdata_i[0]; // R16
					clears[`DSF_F_B_HIGH] = reg_wdata_i[1]; // R15
					clears[`DSF_F_A_LOW] = reg_wdata_i[2]; // R16
					clears[`DSF_F_A_HIGH] = reg_wdata_i[3]; // R15
				end
				default:
				begin
					clears = '0;
				end
			endcase
		end
	end

	// ==========================================================
	// Sticky flag cells, one per fault
	genvar gi;
	generate
		for (gi = 0; gi < `DSF_NUM_FLAGS; gi = gi + 1)
		begin : g_flag
			dsf_flag_cell u_cell
			(
				.clk_i(clk_i),
				.rstn_i(rstn_i),
				.event_i(events[gi]),
				.clear_i(clears[gi]),
				.flag_o(flags[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Fuse bank indicator, caught once after reset release
	logic bank_d;
	logic bank_q; // 1 primary bank, 0 backup bank
	logic caught_d;
	logic caught_q; // Set once the bank has been sampled

	// Sample the loader level in the first cycle out of reset
	always_comb
	begin
		bank_d = bank_q;
		caught_d = 1'b1;
		if (!caught_q)
		begin
			bank_d = fuse_bank_primary_i; // R11
		end
	end

	// Register; reset shows the primary bank until sampled
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			bank_q <= 1'b1;
			caught_q <= 1'b0;
		end
		else
		begin
			bank_q <= bank_d;
			caught_q <= caught_d;
		end
	end

	// ==========================================================
	// Read data assembly
	dsf_pkg::dsf_word_t clock_word; // Clock status view
	dsf_pkg::dsf_word_t digital_word; // Digital status view
	dsf_pkg::dsf_word_t occ_word; // Overcurrent status view

	// Fixed reserved fields around the live flags
	always_comb
	begin
		clock_word = {`DSF_CLK_RSVD, flags[`DSF_F_MCLK_FREQ],
			flags[`DSF_F_OSC_WD], flags[`DSF_F_MCLK_WD]}; // R1
		digital_word = {flags[`DSF_F_SEC_ONE], flags[`DSF_F_SEC_TWO],
			flags[`DSF_F_SEC_THREE], 1'b0, flags[`DSF_F_MEM],
			bank_q, `DSF_DIG_LOW_RSVD}; // R8
		occ_word = {`DSF_OCC_RSVD, flags[`DSF_F_A_HIGH],
			flags[`DSF_F_A_LOW], flags[`DSF_F_B_HIGH],
			flags[`DSF_F_B_LOW]}; // R14
	end

	// ==========================================================
	// Read port and summary output
	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic rvalid_d;
	logic rvalid_q;
	logic summary_d;
	logic summary_q;

	// Pick the addressed word; unmapped offsets read zero
	always_comb
	begin
		rdata_d = rdata_q;
		rvalid_d = reg_rd_i;
		if (reg_rd_i)
		begin
			case (sel)
				dsf_pkg::DSF_SEL_CLOCK: rdata_d = clock_word;
				dsf_pkg::DSF_SEL_DIGITAL: rdata_d = digital_word;
				dsf_pkg::DSF_SEL_OCC: rdata_d = occ_word;
				default: rdata_d = 16'h0000;
			endcase
		end
		// Bank indicator is left out of the summary
		summary_d = flags[`DSF_F_SEC_ONE] & flags[`DSF_F_SEC_TWO] &
			flags[`DSF_F_SEC_THREE] & flags[`DSF_F_MEM]; // R12
	end

	// Register the read answer and summary
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
			summary_q <= 1'b1;
		end
		else
		begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			summary_q <= summary_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign reg_rvalid_o = rvalid_q;
	assign summary_digital_fault_n_o = summary_q;

	// ==========================================================
	// Checks
	sequence s_rd_clock;
		reg_rd_i && (reg_addr_i == `DSF_OFS_CLOCK);
	endsequence

	sequence s_rd_digital;
		reg_rd_i && (reg_addr_i == `DSF_OFS_DIGITAL);
	endsequence

	sequence s_rd_occ;
		reg_rd_i && (reg_addr_i == `DSF_OFS_OCC);
	endsequence

	property p_clock_rsvd;
		@(posedge clk_i) disable iff (!rstn_i)
		s_rd_clock |=> reg_rvalid_o && (reg_rdata_o[15:3] == 13'h1F80);
	endproperty
	a_clock_rsvd: assert property (p_clock_rsvd) // R1
		else $error("clock status reserved bits wrong");

	property p_digital_rsvd;
		@(posedge clk_i) disable iff (!rstn_i)
		s_rd_digital |=> !reg_rdata_o[12] && (reg_rdata_o[9:0] == 10'h000)
			&& (reg_rdata_o[10] == $past(bank_q));
	endproperty
	a_digital_rsvd: assert property (p_digital_rsvd) // R8
		else $error("digital status reserved or bank bit wrong");

	property p_occ_rsvd;
		@(posedge clk_i) disable iff (!rstn_i)
		s_rd_occ |=> reg_rdata_o[15:4] == 12'h000;
	endproperty
	a_occ_rsvd: assert property (p_occ_rsvd) // R14
		else $error("overcurrent reserved bits not zero");

	property p_clock_fault_read;
		@(posedge clk_i) disable iff (!rstn_i)
		main_clk_freq_fault_i ##1 s_rd_clock |=> !reg_rdata_o[2];
	endproperty
	a_clock_fault_read: assert property (p_clock_fault_read) // R2
		else $error("frequency fault not visible in read");

	property p_summary;
		@(posedge clk_i) disable iff (!rstn_i)
		regsec_one_crc_i |=> ##1 !summary_digital_fault_n_o;
	endproperty
	a_summary: assert property (p_summary) // R12
		else $error("summary fault not raised by section CRC");

	property p_bank_free;
		@(posedge clk_i) disable iff (!rstn_i)
		(&flags[6:3]) |=> summary_digital_fault_n_o;
	endproperty
	a_bank_free: assert property (p_bank_free) // R12
		else $error("summary fault without digital flag");

	property p_bank_stable;
		@(posedge clk_i) disable iff (!rstn_i)
		caught_q |=> $stable(bank_q);
	endproperty
	a_bank_stable: assert property (p_bank_stable) // R11
		else $error("bank indicator changed after capture");
endmodule
`default_nettype wire

// *** verification/diagnostic_status_flags_test.sv ***
// Self-checking bench for the diagnostic status flag bank
`include "dsf_params.svh"
`default_nettype none
module diagnostic_status_flags_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Signals
	logic clk_i;
	logic rstn_i;
	logic [`DSF_ADDR_W-1:0] reg_addr_i;
	logic reg_wr_i;
	logic [15:0] reg_wdata_i;
	logic reg_rd_i;
	logic [15:0] reg_rdata_o;
	logic reg_rvalid_o;
	logic summary_n;
	logic [10:0] ev; // Fault event per flag, bench order
	logic bank_primary; // Fuse loader level
	logic [15:0] d; // Last read word
	int num_errors;
	int checked;
	int cycles;

	// ==========================================================
	// Device under test
	dsf_status_regs u_dut
	(
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o),
		.main_clk_freq_fault_i(ev[2]),
		.diag_osc_watchdog_i(ev[1]),
		.main_clk_watchdog_i(ev[0]),
		.regsec_one_crc_i(ev[3]),
		.regsec_two_crc_i(ev[4]),
		.regsec_three_crc_i(ev[5]),
		.internal_memory_crc_i(ev[6]),
		.chan_a_high_limit_i(ev[10]),
		.chan_a_low_limit_i(ev[9]),
		.chan_b_high_limit_i(ev[8]),
		.chan_b_low_limit_i(ev[7]),
		.fuse_bank_primary_i(bank_primary),
		.summary_digital_fault_n_o(summary_n)
	);

	// ==========================================================
	// Clock and cycle limit
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// Cuts a hang short
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			$display("mismatch at %0t: run too long", $time);
			num_errors++;
			complete_run();
		end
	end

	// ==========================================================
	// Helpers
	// Register offset of each event's flag
	function automatic logic [7:0] ev_addr(input int i);
		return (i < 3) ? `DSF_OFS_CLOCK :
			(i < 7) ? `DSF_OFS_DIGITAL : `DSF_OFS_OCC;
	endfunction

	// Bit mask of each event's flag
	function automatic logic [15:0] ev_mask(input int i);
		case (i)
			3: return 16'h8000;
			4: return 16'h4000;
			5: return 16'h2000;
			6: return 16'h0800;
			default: return 16'h0001 << ((i < 3) ? i : i - 7);
		endcase
	endfunction

	// Fault-free word at an offset
	function automatic logic [15:0] rv(input logic [7:0] a);
		case (a)
			8'h04: return 16'hFC07;
			8'h05: return bank_primary ? 16'hEC00 : 16'hE800;
			8'h06: return 16'h000F;
			default: return 16'h0000;
		endcase
	endfunction

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask

	// Read one word, checking the one-cycle answer
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk({15'h0000, reg_rvalid_o}, 16'h0001);
		d = reg_rdata_o;
	endtask

	// One-cycle fault event on one flag
	task automatic pulse(input int i);
		@(posedge clk_i);
		ev[i] <= 1'b1;
		@(posedge clk_i);
		ev[i] <= 1'b0;
	endtask

	// Write one word
	task automatic wr(input logic [7:0] a, input logic [15:0] w);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= w;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Reset, then check every offset and the summary
	task automatic reset_and_check();
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		// Read port idles with cleared data out of reset
		#1;
		chk(reg_rdata_o, 16'h0000);
		chk({15'h0000, reg_rvalid_o}, 16'h0000);
		for (int a = 4; a < 8; a++)
		begin
			rd(8'(a));
			chk(d, rv(8'(a)));
		end
		chk({15'h0000, summary_n}, 16'h0001);
	endtask

	// Verdict and end of run
	task automatic complete_run();
		$display("errors %0d, comparisons %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		rstn_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_wdata_i = 16'h0000;
		reg_rd_i = 1'b0;
		ev = 11'h000;
		bank_primary = 1'b1;
		num_errors = 0;
		checked = 0;
		cycles = 0;
		reset_and_check();
		// Each flag: drop, zero write, fault beating clear, restore
		for (int i = 0; i < 11; i++)
		begin
			@(posedge clk_i);
			ev[i] <= 1'b1;
			@(posedge clk_i);
			ev[i] <= 1'b0;
			rd(ev_addr(i));
			chk(d, rv(ev_addr(i)) & ~ev_mask(i));
			chk({15'h0000, summary_n}, (i > 2 && i < 7) ? 16'h0 : 16'h1);
			wr(ev_addr(i), ~ev_mask(i));
			rd(ev_addr(i));
			chk(d, rv(ev_addr(i)) & ~ev_mask(i));
			@(posedge clk_i);
			ev[i] <= 1'b1;
			reg_wr_i <= 1'b1;
			reg_addr_i <= ev_addr(i);
			reg_wdata_i <= ev_mask(i);
			@(posedge clk_i);
			ev[i] <= 1'b0;
			reg_wr_i <= 1'b0;
			rd(ev_addr(i));
			chk(d, rv(ev_addr(i)) & ~ev_mask(i));
			wr(ev_addr(i), ev_mask(i));
			rd(ev_addr(i));
			chk(d, rv(ev_addr(i)));
			chk({15'h0000, summary_n}, 16'h0001);
		end
		// Writes of all ones and zeros leave fixed bits alone
		for (int a = 4; a < 8; a++)
		begin
			wr(8'(a), 16'hFFFF);
			wr(8'(a), 16'h0000);
			rd(8'(a));
			chk(d, rv(8'(a)));
		end
		// Memory fault returns after a clear: host resets
		pulse(6);
		wr(`DSF_OFS_DIGITAL, 16'h0800);
		pulse(6);
		rd(`DSF_OFS_DIGITAL);
		chk(d, 16'hE400);
		reset_and_check();
		// Backup fuse bank shows in bit 10 only
		@(posedge clk_i);
		bank_primary <= 1'b0;
		reset_and_check();
		// Backup bank seen: host resets onto the primary bank
		@(posedge clk_i);
		bank_primary <= 1'b1;
		reset_and_check();
		complete_run();
	end
endmodule
`default_nettype wire
